// [rtl/gxa_expander.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - address with write bit starts register write
// - first written byte loads the register pointer
// - each data byte flips pointer within pair
// - unlimited data bytes per write transaction
// - restart plus read address returns pointed register
// - pins latch into input register at ack
// - further read bytes alternate within the pair
// - input pin change asserts open-drain interrupt
// - interrupt clears on return or port read
// - output-configured pins never raise the interrupt
// - interrupt clearing is tracked per port
// - output-to-input switch may raise interrupt
// - stop anywhere keeps last acknowledged data
// - pointer 0..7 selects input, output, polarity, config
// - input registers follow pins, writes ignored
// - polarity bit one inverts input read data
// - config one means input, zero drives output
module gxa_expander
    import gxa_pkg::*;
#(
    parameter logic [3:0] FIXED_ADDR = ADDR_FIXED
) (
    input  wire logic                 MCLK,
    input  wire logic                 RST,
    input  wire logic                 SCL,
    input  wire logic                 SDA_IN,
    output logic                      SDA_OUT,
    output logic                      SDA_OE,
    output logic                      INT_OUT,
    output logic                      INT_OE,
    input  wire logic                 ADDR_STRAP_0,
    input  wire logic                 ADDR_STRAP_1,
    input  wire logic                 ADDR_STRAP_2,
    input  wire logic [PIN_COUNT-1:0] IO_IN,
    output logic      [PIN_COUNT-1:0] IO_OUT,
    output logic      [PIN_COUNT-1:0] IO_OE
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } gxa_state_e;

    typedef struct packed {
        gxa_state_e state;
        logic       scl_d;
        logic       sda_d;
        logic [7:0] shreg;
        logic [3:0] bit_cnt;
        logic       addr_ph;
        logic       cmd_ph;
        logic       rw;
        logic       mack;
        logic [2:0] ptr;
        logic       sda_oe;
        logic       int_oe;
        logic       od_level;
        gxa_pair_t  in_reg;
        gxa_pair_t  out_reg;
        gxa_pair_t  pol_reg;
        gxa_pair_t  drive;
    } gxa_state_s;

    gxa_state_s       st_ff;
    gxa_state_s       nxt_st;
    logic [SYN_W-1:0] syn;
    logic             scl;
    logic             sda;
    logic [2:0]       strap;
    gxa_pair_t        pins;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_cond;
    logic             stop_cond;

    gxa_sync #(
        .W (SYN_W)
    ) u_sync (
        .MCLK (MCLK),
        .RST  (RST),
        .D    ({IO_IN, ADDR_STRAP_2, ADDR_STRAP_1, ADDR_STRAP_0, SDA_IN, SCL}),
        .Q    (syn)
    );

    assign scl   = syn[SYN_SCL];
    assign sda   = syn[SYN_SDA];
    assign strap = syn[SYN_STRAP +: STRAP_COUNT];
    assign pins  = syn[SYN_IO +: PIN_COUNT];

    assign scl_rise   = scl & ~st_ff.scl_d;
    assign scl_fall   = ~scl & st_ff.scl_d;
    assign start_cond = scl & st_ff.scl_d & st_ff.sda_d & ~sda;
    assign stop_cond  = scl & st_ff.scl_d & ~st_ff.sda_d & sda;

    // read value of the register at pointer p
    function automatic logic [7:0] reg_read(
        input logic [2:0] p,
        input gxa_pair_t  in_r,
        input gxa_pair_t  out_r,
        input gxa_pair_t  pol_r,
        input gxa_pair_t  drv_r
    );
        logic [7:0] v;
        v = 8'h00;
        case (p[2:1])
            GRP_IN:  v = in_r[p[0]] ^ pol_r[p[0]];
            GRP_OUT: v = out_r[p[0]];
            GRP_POL: v = pol_r[p[0]];
            GRP_CFG: v = ~drv_r[p[0]];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // latch the addressed input port, then put its first bit on the line
    function automatic gxa_state_s load_byte(input gxa_state_s c, input gxa_pair_t pv);
        gxa_state_s r;
        r = c;
        if (r.ptr[2:1] == GRP_IN) begin
            r.in_reg[r.ptr[0]] = pv[r.ptr[0]];
        end
        r.shreg   = reg_read(r.ptr, r.in_reg, r.out_reg, r.pol_reg, r.drive);
        r.sda_oe  = ~r.shreg[7];
        r.bit_cnt = '0;
        r.state   = ST_TX;
        return r;
    endfunction

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.scl_d = scl;
        nxt_st.sda_d = sda;
        // only pins set as inputs are compared against their latched value
        nxt_st.int_oe = |((pins ^ st_ff.in_reg) & ~st_ff.drive);

        case (st_ff.state)
            ST_IDLE: begin
                nxt_st.sda_oe = 1'b0;
            end
            ST_RX: begin
                if (scl_rise && st_ff.bit_cnt != BYTE_BITS) begin
                    nxt_st.shreg   = {st_ff.shreg[6:0], sda};
                    nxt_st.bit_cnt = st_ff.bit_cnt + BIT_ONE;
                end
                if (scl_fall && st_ff.bit_cnt == BYTE_BITS) begin
                    nxt_st.sda_oe  = 1'b1;
                    nxt_st.state   = ST_ACK;
                    nxt_st.bit_cnt = '0;
                    if (st_ff.addr_ph) begin
                        if (st_ff.shreg[7:1] != {FIXED_ADDR, strap}) begin
                            nxt_st.sda_oe = 1'b0;
                            nxt_st.state  = ST_IDLE;
                        end
                        nxt_st.rw = st_ff.shreg[0];
                    end else if (st_ff.cmd_ph) begin
                        nxt_st.ptr    = st_ff.shreg[2:0];
                        nxt_st.cmd_ph = 1'b0;
                    end else begin
                        // committed at the acknowledge, so a later stop keeps it
                        case (st_ff.ptr[2:1])
                            GRP_OUT: nxt_st.out_reg[st_ff.ptr[0]] = st_ff.shreg;
                            GRP_POL: nxt_st.pol_reg[st_ff.ptr[0]] = st_ff.shreg;
                            GRP_CFG: nxt_st.drive[st_ff.ptr[0]]   = ~st_ff.shreg;
                            default: nxt_st.ptr = st_ff.ptr;
                        endcase
                        nxt_st.ptr = st_ff.ptr ^ PTR_PAIR;
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    nxt_st.sda_oe  = 1'b0;
                    nxt_st.addr_ph = 1'b0;
                    nxt_st.state   = ST_RX;
                    if (st_ff.addr_ph && st_ff.rw != RW_WRITE) begin
                        nxt_st = load_byte(nxt_st, pins);
                    end
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    nxt_st.bit_cnt = st_ff.bit_cnt + BIT_ONE;
                    if (st_ff.bit_cnt == BIT_LAST) begin
                        nxt_st.sda_oe = 1'b0;
                        nxt_st.state  = ST_MACK;
                    end else begin
                        nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
                        nxt_st.sda_oe = ~st_ff.shreg[6];
                    end
                end
            end
            ST_MACK: begin
                if (scl_rise) begin
                    nxt_st.mack = ~sda;
                end
                if (scl_fall) begin
                    if (st_ff.mack) begin
                        nxt_st.ptr = st_ff.ptr ^ PTR_PAIR;
                        nxt_st     = load_byte(nxt_st, pins);
                    end else begin
                        // a missing acknowledge ends the read
                        nxt_st.state = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.state  = ST_IDLE;
                nxt_st.sda_oe = 1'b0;
            end
        endcase

        // start and stop win over any byte in flight
        if (start_cond) begin
            nxt_st.state   = ST_RX;
            nxt_st.addr_ph = 1'b1;
            nxt_st.cmd_ph  = 1'b1;
            nxt_st.bit_cnt = '0;
            nxt_st.sda_oe  = 1'b0;
        end else if (stop_cond) begin
            nxt_st.state  = ST_IDLE;
            nxt_st.sda_oe = 1'b0;
        end

        if (RST) begin
            nxt_st         = '0;
            nxt_st.state   = ST_IDLE;
            nxt_st.scl_d   = 1'b1;
            nxt_st.sda_d   = 1'b1;
            nxt_st.ptr     = PTR_RST;
            nxt_st.out_reg = {PORT_COUNT{OUT_RST}};
            nxt_st.pol_reg = {PORT_COUNT{POL_RST}};
            nxt_st.drive   = ~{PORT_COUNT{CFG_RST}};
        end
    end

    always_ff @(posedge MCLK) begin
        st_ff <= nxt_st;
    end

    assign SDA_OUT = st_ff.od_level;
    assign SDA_OE  = st_ff.sda_oe;
    assign INT_OUT = st_ff.od_level;
    assign INT_OE  = st_ff.int_oe;
    assign IO_OUT  = st_ff.out_reg;
    assign IO_OE   = st_ff.drive;

endmodule

// [rtl/gxa_pkg.sv]
package gxa_pkg;

    localparam int          PORT_BITS   = 8;
    localparam int          PORT_COUNT  = 2;
    localparam int          PIN_COUNT   = PORT_BITS * PORT_COUNT;
    localparam int          STRAP_COUNT = 3;

    // fixed upper bits of the seven-bit bus address, straps fill the low three
    localparam logic [3:0]  ADDR_FIXED  = 4'h4;

    localparam logic        RW_WRITE    = 1'b0;

    // register pointer: bits [2:1] pick the pair, bit 0 the port inside it
    localparam logic [1:0]  GRP_IN      = 2'h0;
    localparam logic [1:0]  GRP_OUT     = 2'h1;
    localparam logic [1:0]  GRP_POL     = 2'h2;
    localparam logic [1:0]  GRP_CFG     = 2'h3;
    localparam logic [2:0]  PTR_RST     = 3'h0;
    localparam logic [2:0]  PTR_PAIR    = 3'h1;

    localparam logic [7:0]  OUT_RST     = 8'hFF;
    localparam logic [7:0]  POL_RST     = 8'h00;
    localparam logic [7:0]  CFG_RST     = 8'hFF;

    localparam logic [3:0]  BIT_LAST    = 4'h7;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [3:0]  BIT_ONE     = 4'h1;

    // positions inside the synchronised input vector
    localparam int          SYN_SCL     = 0;
    localparam int          SYN_SDA     = 1;
    localparam int          SYN_STRAP   = 2;
    localparam int          SYN_IO      = SYN_STRAP + STRAP_COUNT;
    localparam int          SYN_W       = SYN_IO + PIN_COUNT;

    typedef logic [PORT_COUNT-1:0][PORT_BITS-1:0] gxa_pair_t;

endpackage

// [rtl/gxa_sync.sv]
`timescale 1ns/1ps
module gxa_sync
    import gxa_pkg::*;
#(
    parameter int W = SYN_W
) (
    input  wire logic         MCLK,
    input  wire logic         RST,
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } gxa_sync_s;

    gxa_sync_s st_ff;
    gxa_sync_s nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = D;
        // first stage feeds only the second stage
        nxt_st.safe = st_ff.meta;
        if (RST) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge MCLK) begin
        st_ff <= nxt_st;
    end

    assign Q = st_ff.safe;

endmodule

// [verif/gxa_expander_sva.sv]
`timescale 1ns/1ps
module gxa_expander_chk
    import gxa_pkg::*;
(
    input wire logic                 MCLK,
    input wire logic                 RST,
    input wire logic                 SCL,
    input wire logic                 SDA_IN,
    input wire logic                 SDA_OUT,
    input wire logic                 SDA_OE,
    input wire logic                 INT_OUT,
    input wire logic                 INT_OE,
    input wire logic [PIN_COUNT-1:0] IO_IN,
    input wire logic [PIN_COUNT-1:0] IO_OUT,
    input wire logic [PIN_COUNT-1:0] IO_OE
);
    logic                 scl_ff;
    logic [3:0]           age_ff;
    logic [3:0]           quiet_ff;
    logic [PIN_COUNT-1:0] pin_ff;
    logic [PIN_COUNT-1:0] oe_ff;
    // ages since the last bus clock fall and since the last input-side change
    always_ff @(posedge MCLK) begin
        scl_ff <= SCL;
        pin_ff <= IO_IN & ~IO_OE;
        oe_ff  <= IO_OE;
        if (RST || (scl_ff && !SCL)) age_ff <= 4'h0;
        else if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
        if (RST || pin_ff != (IO_IN & ~IO_OE) || oe_ff != IO_OE) quiet_ff <= 4'h0;
        else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_stop;
        SCL && $past(SCL) && $rose(SDA_IN);
    endsequence
    sequence s_fall_near;
        age_ff inside {[4'h1:4'h6]};
    endsequence
    sda_level_a: assert property (!SDA_OUT && !INT_OUT)
        else $error("open-drain level driven high");
    sda_timing_a: assert property ($changed(SDA_OE) |-> s_fall_near)
        else $error("data drive changed away from a clock fall");
    cfg_timing_a: assert property ($changed(IO_OE) |-> s_fall_near)
        else $error("pin direction changed away from a clock fall");
    out_timing_a: assert property ($changed(IO_OUT) |-> s_fall_near)
        else $error("output value changed away from a clock fall");
    reset_vals_a: assert property ($fell(RST) |-> IO_OE == '0 && IO_OUT == '1 && !SDA_OE)
        else $error("wrong values after reset");
    int_cause_a: assert property ($rose(INT_OE) |-> quiet_ff < 4'h8)
        else $error("interrupt raised without an input change");
    int_clear_a: assert property ($fell(INT_OE) |-> quiet_ff < 4'h8 || age_ff < 4'h8)
        else $error("interrupt dropped without cause");
    stop_idle_a: assert property (s_stop |=> !SDA_OE [*8])
        else $error("data line driven after stop");
endmodule
bind gxa_expander gxa_expander_chk u_chk (.MCLK(MCLK), .RST(RST), .SCL(SCL),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .INT_OUT(INT_OUT),
    .INT_OE(INT_OE), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE));

// [verif/gxa_i2c_master.sv]
`timescale 1ns/1ps
module gxa_i2c_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // serves as start and repeated start; clock stays low 150 ns so the device
    // has let go of an acknowledge before the clock rises, else a stop is seen
    task automatic start;
        sda_low = 1'b0;
        #150 scl = 1'b1;
        #100 sda_low = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic stop;
        #50 sda_low = 1'b1;
        #100 scl = 1'b1;
        #100 sda_low = 1'b0;
        #100;
    endtask
    task automatic bit_io(input logic b, output logic r);
        #50 sda_low = !b;
        #100 scl = 1'b1;
        r = sda;
        #100 scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // the last byte of a read goes unacknowledged
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
    endtask
endmodule

// [verif/gxa_expander_tb.sv]
`timescale 1ns/1ps
module gxa_expander_tb import gxa_pkg::*;;
    logic        MCLK, RST, scl, sda_low, sda, sda_oe, int_oe, a;
    logic [2:0]  strap = 3'h5;
    logic [15:0] ext = 16'h0000, io_in, io_out, io_oe;
    logic [7:0]  rb [0:2];
    int          fails = 0, num_checks = 0, cyc = 0;
    assign sda = !(sda_low || sda_oe);
    assign io_in = (io_oe & io_out) | (~io_oe & ext);
    gxa_i2c_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
    gxa_expander DUT (.MCLK(MCLK), .RST(RST), .SCL(scl), .SDA_IN(sda), .SDA_OUT(),
        .SDA_OE(sda_oe), .INT_OUT(), .INT_OE(int_oe), .ADDR_STRAP_0(strap[0]),
        .ADDR_STRAP_1(strap[1]), .ADDR_STRAP_2(strap[2]), .IO_IN(io_in),
        .IO_OUT(io_out), .IO_OE(io_oe));
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input int n, input logic [23:0] d);
        @(negedge MCLK);
        m.start();
        m.wr_byte({ADDR_FIXED, strap, RW_WRITE}, a);
        chk("addr ack", a, 1'b1);
        m.wr_byte(cmd, a);
        chk("cmd ack", a, 1'b1);
        for (int i = 0; i < n; i++) m.wr_byte(d[23-8*i -: 8], a);
        chk("data ack", a, 1'b1);
        m.stop();
    endtask
    task automatic rd(input logic [7:0] cmd, input int n);
        @(negedge MCLK);
        m.start();
        m.wr_byte({ADDR_FIXED, strap, RW_WRITE}, a);
        m.wr_byte(cmd, a);
        m.start();
        m.wr_byte({ADDR_FIXED, strap, 1'b1}, a);
        chk("read ack", a, 1'b1);
        for (int i = 0; i < n; i++) m.rd_byte(i < n - 1, rb[i]);
        m.stop();
    endtask
    task automatic t_reset;
        chk("oe", io_oe, 16'h0000);
        chk("out", io_out, 16'hFFFF);
        rd(8'h06, 2);
        chk("cfg", {rb[0], rb[1]}, 16'hFFFF);
        rd(8'h04, 2);
        chk("pol", {rb[0], rb[1]}, 16'h0000);
    endtask
    task automatic t_pair;
        wr(8'h03, 3, 24'hA53C0F);
        chk("out", io_out, 16'h0F3C);
        wr(8'h07, 2, 24'hF00F00);
        chk("oe", io_oe, 16'h0FF0);
        rd(8'h02, 3);
        chk("rd pair", {rb[0], rb[1]}, 16'h3C0F);
        chk("rd wrap", rb[2], 8'h3C);
    endtask
    task automatic t_input;
        ext = 16'h5AC3;
        wr(8'h01, 1, 24'h770000);
        wr(8'h04, 2, 24'hFF0000);
        rd(8'h01, 2);
        chk("in", {rb[0], rb[1]}, 16'h5FCC);
        wr(8'h04, 2, 24'h000000);
        wr(8'h06, 2, 24'hFFFF00);
        rd(8'h00, 2);
        chk("in raw", {rb[1], rb[0]}, 16'h5AC3);
    endtask
    task automatic pin(input int b, input logic exp);
        @(negedge MCLK);
        ext[b] = ~ext[b];
        repeat (10) @(negedge MCLK);
        chk("int", int_oe, exp);
    endtask
    task automatic t_int;
        chk("int idle", int_oe, 1'b0);
        pin(0, 1'b1);
        pin(0, 1'b0);
        pin(0, 1'b1);
        pin(8, 1'b1);
        rd(8'h01, 1);
        chk("int port1", int_oe, 1'b1);
        rd(8'h00, 1);
        chk("int port0", int_oe, 1'b0);
        wr(8'h06, 1, 24'hFE0000);
        wr(8'h02, 1, 24'h3D0000);
        repeat (10) @(negedge MCLK);
        chk("int out pin", int_oe, 1'b0);
        pin(0, 1'b0);
        wr(8'h06, 1, 24'hFF0000);
        repeat (10) @(negedge MCLK);
        chk("int cfg in", int_oe, 1'b1);
    endtask
    task automatic t_addr_stop;
        @(negedge MCLK);
        m.start();
        m.wr_byte({ADDR_FIXED, strap ^ 3'h1, RW_WRITE}, a);
        chk("foreign ack", a, 1'b0);
        m.stop();
        m.start();
        m.wr_byte({ADDR_FIXED, strap, RW_WRITE}, a);
        m.wr_byte(8'h02, a);
        m.wr_byte(8'h11, a);
        for (int i = 0; i < 4; i++) m.bit_io(1'b1, a);
        m.stop();
        chk("out stop", io_out, 16'h0F11);
    endtask
    task automatic wrap_up;
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        RST = 1'b1;
        repeat (10) @(negedge MCLK);
        RST = 1'b0;
        repeat (5) @(negedge MCLK);
        t_reset();
        t_pair();
        t_input();
        t_int();
        t_addr_stop();
        wrap_up();
    end
endmodule
